// ### sdr_consts.svh
/*
  Constants for the servo decoder status register bank: offsets, bit
  positions, reset values and timing counts.
  Assumes inclusion by its bare name from the package and design modules.
*/
// Function
// R1: Bit 15 shows the missing-timing-mark latch, clears on a written one and resets to zero.
// R2: Bit 13 is high while the masked index and track compares both match, and resets to one; the code gives it no reset and it tracks the live compare.
// R3: Bit 12 is a flag that only the burst sequencer sets and clears.
// R4: Bit 11 sets when the timing-mark output goes active and clears only on a written one.
// R5: Bits 9, 8 and 7 show the live index, data-sector and search-window levels.
// R6: Bit 4 latches when the arm-electronics fault level differs from a write-mode gate.
// R7: Bit 3 latches when the arm-electronics fault level differs from a read-mode gate.
// R8: Both arm-electronics mismatches are sampled only after a debounce delay.
// R9: Bit 2 latches on a shock of selectable polarity and clears on a written one.
// R10: The three fault latches feed write-gate qualification and drive fault when enabled.
// R11: Writing one to bit 0 drops the search window; writing zero does nothing.
// R12: The target register holds a 16-bit track address compared for write-gate qualification.
// R13: Software loads the target register with the destination track at each seek start.
// R14: The search window makes the timing-mark sequencer hunt and drops when a mark is found.
// R15: Set bits of the compare mask are don't-care in the address comparison.
// R16: Written zeros leave sticky bits alone; reserved bits read zero and ignore writes.
`ifndef SDR_CONSTS_SVH
`define SDR_CONSTS_SVH

// Byte offsets on the bus
`define SDR_OFS_STATUS   12'h000
`define SDR_OFS_TARGET   12'h004
`define SDR_OFS_CTRL     12'h008
`define SDR_OFS_IRQ_STAT 12'h00C
`define SDR_OFS_IRQ_MASK 12'h010

// Status bit positions
`define SDR_B_MISS    15
`define SDR_B_CMP     13
`define SDR_B_FLAG    12
`define SDR_B_STM     11
`define SDR_B_INDEX   9
`define SDR_B_DATA_SECTOR_PULSE    8
`define SDR_B_SEARCH_WINDOW    7
`define SDR_B_AEW     4
`define SDR_B_AER     3
`define SDR_B_SHK     2
`define SDR_B_RSRCH   0

// Control register bit positions
`define SDR_C_AEW_EN  0
`define SDR_C_AER_EN  1
`define SDR_C_SHK_EN  2
`define SDR_C_SHK_POL 3
`define SDR_C_WIDTH   4

// Interrupt sources: missing mark, mark found, write err, read err, shock
`define SDR_IRQ_W     5
`define SDR_I_MISS    0
`define SDR_I_STM     1
`define SDR_I_AEW     2
`define SDR_I_AER     3
`define SDR_I_SHK     4

// Reset values
`define SDR_RST_16    16'h0000
`define SDR_RST_CTRL  4'h0
`define SDR_RST_IRQ   5'h00

// Debounce: time in ns, cycle count rounded up at 10 ns clock
`define SDR_DEB_NS    1000
`define SDR_CLK_NS    10
`define SDR_DEB_CYC   ((`SDR_DEB_NS + `SDR_CLK_NS - 1) / `SDR_CLK_NS)
`define SDR_DEB_W     8

`endif

// ### sdr_pkg.sv
/*
  Types for the servo decoder status register bank.
  Assumes sdr_consts.svh is on the include path.
*/
package sdr_pkg;
  `include "sdr_consts.svh"

  // Live servo signals from the decoder core
  typedef struct packed {
    logic timing_mark_found;
    logic missing_mark;
    logic data_sector_pulse;
    logic index_pulse;
    logic flag_set;
    logic flag_clr;
    logic search_clr;
    logic search_set;
  } sdr_servo_t;

  // Fault outputs to write-gate and drive-fault logic
  typedef struct packed {
    logic aew;
    logic aer;
    logic shk;
  } sdr_fault_t;

  // Decoded register access
  typedef enum logic [4:0] {
    SDR_SEL_NONE = 5'b00001,
    SDR_SEL_STAT = 5'b00010,
    SDR_SEL_TGT  = 5'b00100,
    SDR_SEL_CTRL = 5'b01000,
    SDR_SEL_IRQ  = 5'b10000
  } sdr_sel_t;
endpackage : sdr_pkg

// ### sdr_sync.sv
/*
  Two-flop synchroniser for pin inputs.
  Assumes asynchronous pins and one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sdr_sync (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  // Data
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_ff;

  // First stage feeds only the second
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_ff <= 1'b0;
      q_o     <= 1'b0;
    end else begin
      meta_ff <= d_i;
      q_o     <= meta_ff;
    end
  end
endmodule : sdr_sync
`default_nettype wire

// ### sdr_debounce.sv
/*
  Mismatch debouncer: output rises after the input held high
  for the full debounce count, falls at once when it drops.
  Assumes a synchronised input.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sdr_consts.svh"
module sdr_debounce
  import sdr_pkg::*;
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  // Condition
  input  wire logic cond_i,
  output logic      stable_o
);
  logic [`SDR_DEB_W-1:0] cnt_ff;

  // Count while the mismatch persists; transients reset it
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_ff   <= '0;
      stable_o <= 1'b0;
    end else if (!cond_i) begin
      cnt_ff   <= '0;
      stable_o <= 1'b0;
    end else if (cnt_ff == `SDR_DEB_W'(`SDR_DEB_CYC - 1)) begin
      stable_o <= 1'b1; // R8
    end else begin
      cnt_ff <= cnt_ff + `SDR_DEB_W'(1);
    end
  end
endmodule : sdr_debounce
`default_nettype wire

// ### sdr_status_regs.sv
/*
  Servo decoder status and target address register bank on AHB-Lite.
  Holds the sticky event latches, the sequencer flag, the search window,
  the unreset target address and a small control and interrupt block.
  Assumes one clock; fault and shock pins are asynchronous, servo
  signals come from logic on the same clock. The target register has no
  reset, so the compare bit means little until software loads it.
*/
// Our own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sdr_consts.svh"
module sdr_status_regs
  import sdr_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [11:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hwdata_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // Servo decoder core
  input  wire sdr_servo_t  servo_i,
  input  wire logic [15:0] track_addr_i,
  input  wire logic [15:0] track_mask_i,
  input  wire logic        index_match_i,
  input  wire logic        qualified_write_gate_i,
  output logic             search_window_o,
  output logic [15:0]      target_track_address_o,
  // Pins
  input  wire logic        arm_electronics_fault_in_i,
  input  wire logic        shock_sense_in_i,
  // Faults and interrupt
  output sdr_fault_t       fault_o,
  output logic             irq_o
);
  // Bus phase registers
  logic        wr_pend_ff;
  sdr_sel_t    sel_ff;
  logic [15:0]             status_word; // Assembled status, combinational
  logic [15:0]             target_ff;
  logic [`SDR_C_WIDTH-1:0] ctrl_ff;
  logic [`SDR_IRQ_W-1:0]   irq_stat_ff;
  logic [`SDR_IRQ_W-1:0]   irq_mask_ff;
  logic [`SDR_IRQ_W-1:0]   sticky_ff;   // Latched events, interrupt bit order
  logic [`SDR_IRQ_W-1:0]   sticky_clr;  // Written-one clears, same order
  logic                    flag_ff;
  logic                    search_window_ff;
  logic                    stm_prev_ff;
  sdr_sel_t                nxt_sel;
  logic                    addr_is_mask;
  logic [15:0]             wd;
  logic                    wr_stat;
  logic                    wr_tgt;
  logic                    wr_ctrl;
  logic                    wr_irq;
  logic                    wr_mask;
  logic                    ae_s;        // Fault pin after sync
  logic                    shk_s;       // Shock pin after sync
  logic                    aew_ok;      // Write-mode mismatch, debounced
  logic                    aer_ok;      // Read-mode mismatch, debounced
  logic                    shk_act;     // Shock in its active polarity
  logic                    cmp_match;
  logic [`SDR_IRQ_W-1:0]   ev;

  // Zero-wait slave that always answers OKAY
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign wd          = hwdata_i[15:0];

  // Address decode; unmapped offsets read zero, writes dropped
  always_comb begin
    unique case (haddr_i)
      `SDR_OFS_STATUS:   nxt_sel = SDR_SEL_STAT;
      `SDR_OFS_TARGET:   nxt_sel = SDR_SEL_TGT;
      `SDR_OFS_CTRL:     nxt_sel = SDR_SEL_CTRL;
      `SDR_OFS_IRQ_STAT,
      `SDR_OFS_IRQ_MASK: nxt_sel = SDR_SEL_IRQ;
      default:           nxt_sel = SDR_SEL_NONE;
    endcase
  end

  // Capture address phase; a write lands at the edge that closes its data
  // phase, so a read issued straight behind a write to the same register
  // sees the old value unless one idle cycle separates them
  assign addr_is_mask = (haddr_i == `SDR_OFS_IRQ_MASK);
  logic addr_mask_ff;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_pend_ff   <= 1'b0;
      sel_ff       <= SDR_SEL_NONE;
      addr_mask_ff <= 1'b0;
    end else if (hready_i) begin
      wr_pend_ff   <= hsel_i && htrans_i[1] && hwrite_i;
      sel_ff       <= (hsel_i && htrans_i[1]) ? nxt_sel : SDR_SEL_NONE;
      addr_mask_ff <= addr_is_mask;
    end
  end

  // Write strobes, valid in the data phase
  assign wr_stat = wr_pend_ff && (sel_ff == SDR_SEL_STAT);
  assign wr_tgt  = wr_pend_ff && (sel_ff == SDR_SEL_TGT);
  assign wr_ctrl = wr_pend_ff && (sel_ff == SDR_SEL_CTRL);
  assign wr_irq  = wr_pend_ff && (sel_ff == SDR_SEL_IRQ) && !addr_mask_ff;
  assign wr_mask = wr_pend_ff && (sel_ff == SDR_SEL_IRQ) && addr_mask_ff;

  // Pin synchronisers; both pins are asynchronous to the decoder clock,
  // so nothing but the second stage is ever read
  sdr_sync u_sync_ae (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .d_i       (arm_electronics_fault_in_i),
    .q_o       (ae_s)
  );
  sdr_sync u_sync_shk (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .d_i       (shock_sense_in_i),
    .q_o       (shk_s)
  );

  // Debounced mismatch in write and read modes; a gate change shows a
  // short mismatch through the pin sync delay, which the debounce hides
  sdr_debounce u_deb_w (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .cond_i    (qualified_write_gate_i && (ae_s != qualified_write_gate_i)), // R6
    .stable_o  (aew_ok)
  );
  sdr_debounce u_deb_r (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .cond_i    (!qualified_write_gate_i && (ae_s != qualified_write_gate_i)), // R7
    .stable_o  (aer_ok)
  );

  // Shock polarity select
  assign shk_act = shk_s ^ ctrl_ff[`SDR_C_SHK_POL]; // R9

  // Masked compare gated by index match; mask bits are don't-care, so a full
  // mask reads one whenever the index matches, even before the target has been loaded
  assign cmp_match = (((track_addr_i ^ target_ff) & ~track_mask_i) == 16'h0000)
                     && index_match_i; // R2 R15

  // Written-one clears, one per sticky status bit; written zeros do nothing
  assign sticky_clr[`SDR_I_MISS] = wr_stat & wd[`SDR_B_MISS]; // R1 R16
  assign sticky_clr[`SDR_I_STM]  = wr_stat & wd[`SDR_B_STM];  // R4 R16
  assign sticky_clr[`SDR_I_AEW]  = wr_stat & wd[`SDR_B_AEW];  // R6 R16
  assign sticky_clr[`SDR_I_AER]  = wr_stat & wd[`SDR_B_AER];  // R7 R16
  assign sticky_clr[`SDR_I_SHK]  = wr_stat & wd[`SDR_B_SHK];  // R9 R16

  // Mark level one cycle back; resets low like the idle signal, so no
  // false mark follows reset
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stm_prev_ff <= 1'b0;
    end else begin
      stm_prev_ff <= servo_i.timing_mark_found;
    end
  end

  // Sticky latches: set beats a same-cycle clear, so an event that lands
  // on the clearing write is never lost
  for (genvar gi = 0; gi < `SDR_IRQ_W; gi++) begin : g_sticky
    always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        sticky_ff[gi] <= 1'b0;
      end else begin
        sticky_ff[gi] <= ev[gi] | (sticky_ff[gi] & ~sticky_clr[gi]); // R1 R4 R6 R7 R8 R9
      end
    end
  end

  // Sequencer flag, owned by the burst sequencer
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flag_ff <= 1'b0;
    end else if (servo_i.flag_set) begin
      flag_ff <= 1'b1; // R3
    end else if (servo_i.flag_clr) begin
      flag_ff <= 1'b0; // R3
    end
  end

  // Search window; any reset overrides a set
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      search_window_ff <= 1'b0;
    end else if (servo_i.search_clr || (wr_stat && wd[`SDR_B_RSRCH])) begin
      search_window_ff <= 1'b0; // R11 R14
    end else if (servo_i.search_set) begin
      search_window_ff <= 1'b1; // R14
    end
  end
  assign search_window_o = search_window_ff;

  // Target address; target left unreset on purpose
  always_ff @(posedge clk_i) begin
    if (wr_tgt) begin
      target_ff <= wd; // R12 R13
    end
  end
  assign target_track_address_o = target_ff;

  // Control: fault enables and shock polarity
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_ff <= `SDR_RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl_ff <= hwdata_i[`SDR_C_WIDTH-1:0];
    end
  end

  // Fault feed to qualification and drive fault; registered so the far
  // side never sees a glitch from the enable gating
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fault_o <= '0;
    end else begin
      fault_o.aew <= sticky_ff[`SDR_I_AEW] & ctrl_ff[`SDR_C_AEW_EN]; // R10
      fault_o.aer <= sticky_ff[`SDR_I_AER] & ctrl_ff[`SDR_C_AER_EN]; // R10
      fault_o.shk <= sticky_ff[`SDR_I_SHK] & ctrl_ff[`SDR_C_SHK_EN]; // R10
    end
  end

  // Status word; reserved and write-only bits read zero
  always_comb begin
    status_word = `SDR_RST_16;
    status_word[`SDR_B_MISS]  = sticky_ff[`SDR_I_MISS]; // R1
    status_word[`SDR_B_CMP]   = cmp_match; // R2
    status_word[`SDR_B_FLAG]  = flag_ff; // R3
    status_word[`SDR_B_STM]   = sticky_ff[`SDR_I_STM]; // R4
    status_word[`SDR_B_INDEX] = servo_i.index_pulse; // R5
    status_word[`SDR_B_DATA_SECTOR_PULSE]  = servo_i.data_sector_pulse; // R5
    status_word[`SDR_B_SEARCH_WINDOW]  = search_window_ff; // R5
    status_word[`SDR_B_AEW]   = sticky_ff[`SDR_I_AEW]; // R6
    status_word[`SDR_B_AER]   = sticky_ff[`SDR_I_AER]; // R7
    status_word[`SDR_B_SHK]   = sticky_ff[`SDR_I_SHK]; // R9 R16
  end

  // Interrupt events in sticky bit order; the same terms set the latches
  assign ev[`SDR_I_MISS] = servo_i.missing_mark;
  assign ev[`SDR_I_STM]  = servo_i.timing_mark_found & ~stm_prev_ff;
  assign ev[`SDR_I_AEW]  = aew_ok;
  assign ev[`SDR_I_AER]  = aer_ok;
  assign ev[`SDR_I_SHK]  = shk_act;

  // Interrupt status, write one to clear; set beats clear
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_stat_ff <= `SDR_RST_IRQ;
    end else begin
      irq_stat_ff <= ev | (irq_stat_ff & ~({`SDR_IRQ_W{wr_irq}} & hwdata_i[`SDR_IRQ_W-1:0]));
    end
  end

  // Interrupt mask, plain read-write
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_mask_ff <= `SDR_RST_IRQ;
    end else if (wr_mask) begin
      irq_mask_ff <= hwdata_i[`SDR_IRQ_W-1:0];
    end
  end
  assign irq_o = |(irq_stat_ff & irq_mask_ff);

  // Read word chosen from the live address phase; reads have no side
  // effects, so a read never disturbs a sticky bit
  logic [31:0] nxt_rdata;
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    unique case (nxt_sel)
      SDR_SEL_STAT: nxt_rdata = {16'h0000, status_word};
      SDR_SEL_TGT:  nxt_rdata = {16'h0000, target_ff};
      SDR_SEL_CTRL: nxt_rdata = {28'h0000000, ctrl_ff};
      SDR_SEL_IRQ:  nxt_rdata = {27'h0, addr_is_mask ? irq_mask_ff : irq_stat_ff};
      SDR_SEL_NONE: nxt_rdata = 32'h0000_0000;
    endcase
  end

  // Read data registered at the address edge, held until the next read
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (hready_i && hsel_i && htrans_i[1] && !hwrite_i) begin
      hrdata_o <= nxt_rdata;
    end
  end
endmodule : sdr_status_regs
`default_nettype wire

// ### sdr_status_regs_props.sv
/*
  Port checker for the servo decoder status register bank.
  Assumes one clock, async active-low reset, bound to every instance.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sdr_consts.svh"
module sdr_status_regs_props
  import sdr_pkg::*;
(
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  // Bus
  input wire logic        hsel_i,
  input wire logic [11:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic        hready_i,
  input wire logic [31:0] hwdata_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  // Servo side
  input wire sdr_servo_t  servo_i,
  input wire logic [15:0] track_addr_i,
  input wire logic [15:0] track_mask_i,
  input wire logic        index_match_i,
  input wire logic        search_window_o,
  input wire logic [15:0] target_track_address_o
);
  // Taken requests and the compare the status bit must follow
  wire rd_any = hsel_i & htrans_i[1] & hready_i & !hwrite_i;
  wire rd_st  = rd_any & (haddr_i == `SDR_OFS_STATUS);
  wire wr_tgt = hsel_i & htrans_i[1] & hready_i & hwrite_i & (haddr_i == `SDR_OFS_TARGET);
  wire wr_st  = hsel_i & htrans_i[1] & hready_i & hwrite_i & (haddr_i == `SDR_OFS_STATUS);
  wire cmp_w  = index_match_i & ~|((track_addr_i ^ target_track_address_o) & ~track_mask_i);

  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  ready_always_a: assert property (hreadyout_o) else $error("hreadyout low");
  resp_okay_a: assert property (!hresp_o) else $error("hresp not OKAY");
  search_window_set_a: assert property (servo_i.search_set && !servo_i.search_clr
    && !($past(wr_st) && hwdata_i[0]) |=> search_window_o)
    else $error("search window not raised");
  search_window_wr_clr_a: assert property ($past(wr_st) && hwdata_i[0] |=> !search_window_o)
    else $error("search window not dropped by write");
  search_window_clr_a: assert property (servo_i.search_clr |=> !search_window_o)
    else $error("search window not cleared");
  resv_zero_a: assert property (rd_st |=> (hrdata_o & 32'hFFFF4463) == 32'h0)
    else $error("reserved status bits not zero");
  live_bits_a: assert property (rd_st |=> hrdata_o[9:8] == $past({servo_i.index_pulse,
    servo_i.data_sector_pulse})) else $error("index or sector level wrong");
  search_window_bit_a: assert property (rd_st |=> hrdata_o[7] == $past(search_window_o))
    else $error("search level wrong");
  cmp_bit_a: assert property (rd_st |=> hrdata_o[13] == $past(cmp_w))
    else $error("compare bit wrong");
  unmapped_zero_a: assert property (rd_any && haddr_i >= 12'h014 |=> hrdata_o == 32'h0)
    else $error("unmapped read not zero");
  tgt_write_a: assert property (wr_tgt |-> ##2 target_track_address_o == $past(hwdata_i[15:0]))
    else $error("target not written");

  // Main scenarios reached
  cover property (rd_st);
  cover property (wr_tgt);
  cover property (servo_i.search_set);
endmodule : sdr_status_regs_props

bind sdr_status_regs sdr_status_regs_props u_props (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
  .hready_i(hready_i), .hwdata_i(hwdata_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o), .servo_i(servo_i), .track_addr_i(track_addr_i),
  .track_mask_i(track_mask_i), .index_match_i(index_match_i),
  .search_window_o(search_window_o), .target_track_address_o(target_track_address_o));
`default_nettype wire

// ### sdr_dsp_model.sv
/*
  Processor-side bus master: single word transfers on AHB-Lite.
  Assumes the slave's hreadyout is fed back as hready_i.
*/
`timescale 1ns/1ps
`default_nettype none
module sdr_dsp_model (
  // Clock and answer
  input wire logic        clk_i,
  input wire logic        hready_i,
  input wire logic [31:0] hrdata_i,
  // Request
  output logic            hsel_o,
  output logic [11:0]     haddr_o,
  output logic [1:0]      htrans_o,
  output logic            hwrite_o,
  output logic [2:0]      hsize_o,
  output logic [31:0]     hwdata_o,
  output logic            timed_out_o
);
  // Idle bus at time zero
  initial begin
    hsel_o = 1'b0;
    haddr_o = 12'h000;
    htrans_o = 2'h0;
    hwrite_o = 1'b0;
    hsize_o = 3'h2;
    hwdata_o = 32'h0;
    timed_out_o = 1'b0;
  end

  // One transfer; waits bounded so a dead slave cannot hang the run
  task automatic xfer(input logic wr, input logic [11:0] adr, input logic [31:0] wd,
                      output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    hsel_o <= 1'b1;
    haddr_o <= adr;
    htrans_o <= 2'h2;
    hwrite_o <= wr;
    do begin @(posedge clk_i); n++; end while (hready_i !== 1'b1 && n < 20);
    hsel_o <= 1'b0;
    htrans_o <= 2'h0;
    hwdata_o <= wd;
    do begin @(posedge clk_i); n++; end while (hready_i !== 1'b1 && n < 40);
    rd = hrdata_i;
    hwdata_o <= ~wd; // Released data inverted so stale values never match
    if (n >= 20) timed_out_o <= 1'b1;
  endtask : xfer
endmodule : sdr_dsp_model
`default_nettype wire

// ### servo_decoder_status_regs_tb_top.sv
/*
  Self-checking bench for the status register bank with a bit model.
  Assumes the bound checker and the processor bus model.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sdr_consts.svh"
module servo_decoder_status_regs_tb_top
  import sdr_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        reset_n_i, hsel, hwrite, hready, hresp, irq, search_window, gate, ae, shk, idx, to, a;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, r, q;
  logic [15:0] trk, msk, tgt_o, m_tgt;
  sdr_servo_t  servo;
  sdr_fault_t  flt;
  logic        m_miss, m_stm, m_flag, m_search_window, m_aew, m_aer, m_shk, m_en;
  logic [4:0]  m_irq;
  int          n_fail, n_tests, seed, g;

  always #5 clk_i = ~clk_i;

  sdr_status_regs dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hready_i(hready),
    .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .servo_i(servo), .track_addr_i(trk), .track_mask_i(msk), .index_match_i(idx),
    .qualified_write_gate_i(gate), .search_window_o(search_window), .target_track_address_o(tgt_o),
    .arm_electronics_fault_in_i(ae), .shock_sense_in_i(shk), .fault_o(flt), .irq_o(irq));
  sdr_dsp_model u_dsp (.clk_i(clk_i), .hready_i(hready), .hrdata_i(hrdata), .hsel_o(hsel),
    .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize),
    .hwdata_o(hwdata), .timed_out_o(to));

  task automatic finish_test();
    if (n_fail == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Bus access; a stuck slave ends the run
  task automatic acc(input logic w, input logic [11:0] ad, input logic [31:0] d);
    u_dsp.xfer(w, ad, d, q);
    if (to === 1'b1) begin
      n_fail++;
      finish_test();
    end
  endtask : acc

  task automatic rd(input logic [11:0] ad, input logic [31:0] e);
    acc(1'b0, ad, 32'h0);
    chk(q, e);
  endtask : rd

  // Expected status word from the bit model and the live inputs
  function automatic logic [31:0] est();
    logic c;
    c = idx & (((trk ^ m_tgt) & ~msk) == 16'h0000);
    return {16'h0000, m_miss, 1'b0, c, m_flag, m_stm, 1'b0, servo.index_pulse,
            servo.data_sector_pulse, m_search_window, 2'b00, m_aew, m_aer, m_shk, 2'b00};
  endfunction : est

  // Status read plus search window and fault outputs
  task automatic rs();
    @(posedge clk_i); // Caller's stimulus settles before the model reads it
    rd(`SDR_OFS_STATUS, est());
    chk({28'h0, search_window, flt}, {28'h0, m_search_window, {m_aew, m_aer, m_shk} & {3{m_en}}});
  endtask : rs

  task automatic pulse(input logic [7:0] v);
    @(posedge clk_i);
    servo <= sdr_servo_t'(v);
    @(posedge clk_i);
    servo <= sdr_servo_t'(8'h00);
  endtask : pulse

  initial begin
    {reset_n_i, gate, ae, shk, m_miss, m_stm, m_flag, m_search_window, m_aew, m_aer, m_shk, m_en} = '0;
    {n_fail, n_tests, m_irq} = '0;
    servo = sdr_servo_t'(8'h00);
    trk = 16'h0000;
    msk = 16'hFFFF;
    idx = 1'b1;
    seed = 20;
    repeat (6) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rs();
    rd(`SDR_OFS_IRQ_STAT, 32'h0);
    // Target loaded per seek, then matched and mismatched tracks
    for (g = 0; g < 6; g++) begin
      r = $random(seed);
      m_tgt = r[15:0];
      acc(1'b1, `SDR_OFS_TARGET, r);
      rd(`SDR_OFS_TARGET, {16'h0, m_tgt});
      chk({16'h0, tgt_o}, {16'h0, m_tgt});
      r = $random(seed);
      msk <= r[15:0];
      trk <= g[0] ? r[31:16] : m_tgt ^ (r[31:16] & r[15:0]);
      idx <= (g != 4);
      rs();
    end
    servo <= sdr_servo_t'(8'h30);
    rs();
    servo <= sdr_servo_t'(8'h00);
    pulse(8'h08);
    m_flag = 1'b1;
    rs();
    pulse(8'h04);
    m_flag = 1'b0;
    rs();
    pulse(8'hC0);
    {m_miss, m_stm} = 2'b11;
    m_irq |= 5'h03;
    rs();
    acc(1'b1, `SDR_OFS_STATUS, 32'h00007462);
    rs();
    acc(1'b1, `SDR_OFS_STATUS, 32'h00008800);
    {m_miss, m_stm} = 2'b00;
    rs();
    pulse(8'h01);
    m_search_window = 1'b1;
    acc(1'b1, `SDR_OFS_STATUS, 32'h0);
    rs();
    acc(1'b1, `SDR_OFS_STATUS, 32'h1);
    m_search_window = 1'b0;
    rs();
    pulse(8'h01);
    pulse(8'h03);
    rs();
    // Short mismatch must be filtered, long one latched
    acc(1'b1, `SDR_OFS_CTRL, 32'h7);
    m_en = 1'b1;
    for (g = 1; g >= 0; g--) begin
      gate <= g[0];
      ae <= g[0];
      repeat (5) @(posedge clk_i);
      ae <= ~g[0];
      repeat (60) @(posedge clk_i);
      ae <= g[0];
      repeat (5) @(posedge clk_i);
      rs();
      ae <= ~g[0];
      repeat (130) @(posedge clk_i);
      ae <= g[0];
      if (g == 1) m_aew = 1'b1;
      else m_aer = 1'b1;
      m_irq |= (g == 1) ? 5'h04 : 5'h08;
      rs();
    end
    acc(1'b1, `SDR_OFS_STATUS, 32'h18);
    {m_aew, m_aer} = 2'b00;
    rs();
    // Shock in both polarities; idle change may latch, so clear first
    for (g = 0; g < 2; g++) begin
      shk <= g[0];
      acc(1'b1, `SDR_OFS_CTRL, {28'h0, g[0], 3'h7});
      acc(1'b1, `SDR_OFS_STATUS, 32'h4);
      m_shk = 1'b0;
      rs();
      shk <= ~g[0];
      repeat (3) @(posedge clk_i);
      shk <= g[0];
      m_shk = 1'b1;
      m_irq |= 5'h10;
      rs();
      acc(1'b1, `SDR_OFS_STATUS, 32'h4);
      m_shk = 1'b0;
      rs();
    end
    rd(`SDR_OFS_IRQ_STAT, {27'h0, m_irq});
    acc(1'b1, `SDR_OFS_IRQ_MASK, 32'h0);
    rd(`SDR_OFS_IRQ_MASK, 32'h0);
    a = irq;
    acc(1'b1, `SDR_OFS_IRQ_MASK, 32'h1F);
    rd(`SDR_OFS_IRQ_MASK, 32'h1F);
    chk({30'h0, a, irq}, 32'h1); // Masked low, unmasked high
    acc(1'b1, `SDR_OFS_IRQ_STAT, 32'h1F);
    rd(`SDR_OFS_IRQ_STAT, 32'h0);
    chk({31'h0, irq}, 32'h0);
    acc(1'b1, 12'h020, 32'hFFFFFFFF);
    rd(12'h020, 32'h0);
    finish_test();
  end
endmodule : servo_decoder_status_regs_tb_top
`default_nettype wire
